// ---- logic/ingress_pkg.sv ----
// Register map, field positions, reset values and table state codes for the
// switch ingress and priority control block.
// Assumes a 32-bit AXI4-Lite bus with 16-bit byte addresses, one word per register.
package ingress_pkg;

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_VLAN_STS  = 16'h1810;
	localparam logic [15:0] IDX_MAP_CMD   = 16'h1811;
	localparam logic [15:0] IDX_MAP_WDATA = 16'h1812;
	localparam logic [15:0] IDX_MAP_RDATA = 16'h1813;
	localparam logic [15:0] IDX_MAP_PEND  = 16'h1814;
	localparam logic [15:0] IDX_INGR_CFG  = 16'h1840;

	localparam logic [15:0] ADDR_VLAN_STS  = IDX_VLAN_STS * 16'h0004;
	localparam logic [15:0] ADDR_MAP_CMD   = IDX_MAP_CMD * 16'h0004;
	localparam logic [15:0] ADDR_MAP_WDATA = IDX_MAP_WDATA * 16'h0004;
	localparam logic [15:0] ADDR_MAP_RDATA = IDX_MAP_RDATA * 16'h0004;
	localparam logic [15:0] ADDR_MAP_PEND  = IDX_MAP_PEND * 16'h0004;
	localparam logic [15:0] ADDR_INGR_CFG  = IDX_INGR_CFG * 16'h0004;

	localparam int INDEX_W     = 6;
	localparam int PRIO_W      = 3;
	localparam int TABLE_DEPTH = 64;
	localparam int CFG_W       = 14;
	localparam int PORTS_W     = 3;

	// Command register fields
	localparam int CMD_DIR_BIT = 7;

	// Global ingress configuration fields
	localparam int CFG_ECHO      = 13;
	localparam int CFG_IGMP_MSB  = 12;
	localparam int CFG_IGMP_LSB  = 10;
	localparam int CFG_USE_IP    = 9;
	localparam int CFG_IGMP_EN   = 7;
	localparam int CFG_CTR_TEST  = 6;
	localparam int CFG_DA_PRIO   = 5;
	localparam int CFG_FILT_MC   = 4;
	localparam int CFG_DROP_UC   = 3;
	localparam int CFG_USE_PREC  = 2;
	localparam int CFG_TAG_FIRST = 1;
	localparam int CFG_VLAN_EN   = 0;

	localparam logic [13:0] CFG_RESET      = 14'h0006;
	localparam logic [31:0] CTR_TEST_VALUE = 32'h7fff_fffc;
	localparam logic [31:0] CTR_CLEAR_VALUE = 32'h0000_0000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ISSUE   = 2'b01,
		ST_CAPTURE = 2'b10
	} table_state_t;

endpackage

// ---- logic/priority_map_mem.sv ----
// Priority mapping table: 64 entries of 3 bits, one host port, one lookup port.
// Assumes both ports run on mclk; read data appear one cycle after the address.
`timescale 1ns/1ps
module priority_map_mem (
	input  wire logic                                 mclk,
	input  wire logic                                 arst_n,
	input  wire logic                                 host_en,
	input  wire logic                                 host_we,
	input  wire logic [ingress_pkg::INDEX_W-1:0]     host_addr,
	input  wire logic [ingress_pkg::PRIO_W-1:0]      host_wdata,
	output logic      [ingress_pkg::PRIO_W-1:0]      host_rdata,
	input  wire logic [ingress_pkg::INDEX_W-1:0]     lookup_addr,
	output logic      [ingress_pkg::PRIO_W-1:0]      lookup_rdata
);
	import ingress_pkg::*;

	logic [PRIO_W-1:0] table_mem [TABLE_DEPTH];

	// Contents are left unset by reset; software fills the table before use
	always_ff @(posedge mclk)
	begin
		if (host_en && host_we)
		begin
			table_mem[host_addr] <= host_wdata;
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			host_rdata   <= '0;
			lookup_rdata <= '0;
		end
		else
		begin
			if (host_en && !host_we)
			begin
				host_rdata <= table_mem[host_addr];
			end
			lookup_rdata <= table_mem[lookup_addr];
		end
	end

endmodule

// ---- logic/switch_ingress_priority_control.sv ----
// Host-visible ingress and priority control of a switch engine over AXI4-Lite:
// indirect access to the priority mapping table and the global ingress settings.
// Assumes vlan_cmd_busy and lookup_index come from logic on mclk.
`timescale 1ns/1ps
module switch_ingress_priority_control (
	input  wire logic                                 mclk,
	input  wire logic                                 arst_n,
	input  wire logic [15:0]                          awaddr,
	input  wire logic                                 awvalid,
	output logic                                      awready,
	input  wire logic [31:0]                          wdata,
	input  wire logic [3:0]                           wstrb,
	input  wire logic                                 wvalid,
	output logic                                      wready,
	output logic [1:0]                                bresp,
	output logic                                      bvalid,
	input  wire logic                                 bready,
	input  wire logic [15:0]                          araddr,
	input  wire logic                                 arvalid,
	output logic                                      arready,
	output logic [31:0]                               rdata,
	output logic [1:0]                                rresp,
	output logic                                      rvalid,
	input  wire logic                                 rready,
	input  wire logic                                 vlan_cmd_busy,
	input  wire logic [ingress_pkg::INDEX_W-1:0]     lookup_index,
	output logic [ingress_pkg::PRIO_W-1:0]           lookup_priority,
	output logic                                      vlan_enable,
	output logic                                      tag_priority_over_ip,
	output logic                                      vlan_tag_first,
	output logic                                      use_ip_priority,
	output logic                                      ip_priority_from_table,
	output logic                                      da_static_priority,
	output logic                                      drop_unknown_unicast,
	output logic                                      drop_unknown_multicast,
	output logic                                      counter_read_test_mode,
	output logic [31:0]                               counter_reload_value,
	output logic [ingress_pkg::PORTS_W-1:0]          igmp_forward_ports,
	output logic                                      monitor_echo_enable
);
	import ingress_pkg::*;

	typedef struct packed {
		table_state_t        state;
		logic                aw_rdy;
		logic                w_rdy;
		logic                ar_rdy;
		logic                aw_got;
		logic                w_got;
		logic [15:0]         awaddr;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
		logic                cmd_dir;
		logic [INDEX_W-1:0]  cmd_index;
		logic                pend;
		logic [PRIO_W-1:0]   wr_prio;
		logic [PRIO_W-1:0]   rd_prio;
		logic                vlan_busy;
		logic [CFG_W-1:0]    cfg;
		logic [31:0]         ctr_reload;
		logic                ip_table;
		logic                vlan_first;
		logic [PORTS_W-1:0]  igmp_ports;
	} ctrl_state_t;

	ctrl_state_t         r_q;
	ctrl_state_t         r_d;
	logic                wr_do;
	logic                wr_mapped;
	logic                cmd_launch;
	logic                mem_en;
	logic                mem_we;
	logic [INDEX_W-1:0]  mem_addr;
	logic [PRIO_W-1:0]   mem_wdata;
	logic [PRIO_W-1:0]   mem_rdata;

	priority_map_mem u_map (
		.mclk         (mclk),
		.arst_n       (arst_n),
		.host_en      (mem_en),
		.host_we      (mem_we),
		.host_addr    (mem_addr),
		.host_wdata   (mem_wdata),
		.host_rdata   (mem_rdata),
		.lookup_addr  (lookup_index),
		.lookup_rdata (lookup_priority)
	);

	always_comb
	begin
		r_d        = r_q;
		wr_do      = r_q.aw_got && r_q.w_got && !r_q.bvalid;
		cmd_launch = 1'b0;
		wr_mapped  = (r_q.awaddr == ADDR_VLAN_STS) || (r_q.awaddr == ADDR_MAP_CMD)
			|| (r_q.awaddr == ADDR_MAP_WDATA) || (r_q.awaddr == ADDR_MAP_RDATA)
			|| (r_q.awaddr == ADDR_MAP_PEND) || (r_q.awaddr == ADDR_INGR_CFG);
		mem_en     = (r_q.state == ST_ISSUE);
		mem_we     = !r_q.cmd_dir;
		mem_addr   = r_q.cmd_index;
		mem_wdata  = r_q.wr_prio;

		// Address and data may arrive in either order; each is latched alone
		if (awvalid && r_q.aw_rdy)
		begin
			r_d.aw_got = 1'b1;
			r_d.awaddr = awaddr;
		end
		if (wvalid && r_q.w_rdy)
		begin
			r_d.w_got = 1'b1;
			r_d.wdata = wdata;
			r_d.wstrb = wstrb;
		end
		if (r_q.bvalid && bready)
		begin
			r_d.bvalid = 1'b0;
		end

		if (wr_do)
		begin
			r_d.aw_got = 1'b0;
			r_d.w_got  = 1'b0;
			r_d.bvalid = 1'b1;
			r_d.bresp  = wr_mapped ? RESP_OKAY : RESP_SLVERR;
			if (r_q.awaddr == ADDR_MAP_CMD)
			begin
				// A running access must finish on the entry it started with
				if (r_q.wstrb[0] && !r_q.pend)
				begin
					r_d.cmd_dir   = r_q.wdata[CMD_DIR_BIT];
					r_d.cmd_index = r_q.wdata[INDEX_W-1:0];
					r_d.pend      = 1'b1;
					r_d.state     = ST_ISSUE;
					cmd_launch    = 1'b1;
				end
			end
			else if (r_q.awaddr == ADDR_MAP_WDATA)
			begin
				if (r_q.wstrb[0])
				begin
					r_d.wr_prio = r_q.wdata[PRIO_W-1:0];
				end
			end
			else if (r_q.awaddr == ADDR_INGR_CFG)
			begin
				if (r_q.wstrb[0])
				begin
					r_d.cfg[7:0] = r_q.wdata[7:0];
				end
				if (r_q.wstrb[1])
				begin
					r_d.cfg[CFG_W-1:8] = r_q.wdata[CFG_W-1:8];
				end
			end
		end

		if (r_q.rvalid && rready)
		begin
			r_d.rvalid = 1'b0;
		end
		if (arvalid && r_q.ar_rdy)
		begin
			r_d.rvalid = 1'b1;
			r_d.rresp  = RESP_OKAY;
			r_d.rdata  = '0;
			if (araddr == ADDR_VLAN_STS)
			begin
				r_d.rdata[0] = r_q.vlan_busy;
			end
			else if (araddr == ADDR_MAP_CMD)
			begin
				r_d.rdata[CMD_DIR_BIT]   = r_q.cmd_dir;
				r_d.rdata[INDEX_W-1:0]   = r_q.cmd_index;
			end
			else if (araddr == ADDR_MAP_WDATA)
			begin
				r_d.rdata[PRIO_W-1:0] = r_q.wr_prio;
			end
			else if (araddr == ADDR_MAP_RDATA)
			begin
				r_d.rdata[PRIO_W-1:0] = r_q.rd_prio;
			end
			else if (araddr == ADDR_MAP_PEND)
			begin
				r_d.rdata[0] = r_q.pend;
			end
			else if (araddr == ADDR_INGR_CFG)
			begin
				r_d.rdata[CFG_W-1:0] = r_q.cfg;
			end
			else
			begin
				r_d.rresp = RESP_SLVERR;
			end
		end

		case (r_q.state)
			ST_IDLE:
			begin
			end
			ST_ISSUE:
			begin
				r_d.state = ST_CAPTURE;
			end
			ST_CAPTURE:
			begin
				if (r_q.cmd_dir)
				begin
					r_d.rd_prio = mem_rdata;
				end
				r_d.pend  = 1'b0;
				r_d.state = ST_IDLE;
			end
			default:
			begin
				r_d.pend  = 1'b0;
				r_d.state = ST_IDLE;
			end
		endcase

		r_d.aw_rdy    = !r_d.aw_got && !r_d.bvalid;
		r_d.w_rdy     = !r_d.w_got && !r_d.bvalid;
		r_d.ar_rdy    = !r_d.rvalid;
		r_d.vlan_busy = vlan_cmd_busy;

		// Derived selections lag the settings by one cycle to keep outputs registered
		r_d.ctr_reload = r_q.cfg[CFG_CTR_TEST] ? CTR_TEST_VALUE : CTR_CLEAR_VALUE;
		r_d.ip_table   = r_q.cfg[CFG_USE_IP] && !r_q.cfg[CFG_USE_PREC];
		r_d.vlan_first = r_q.cfg[CFG_VLAN_EN] && r_q.cfg[CFG_TAG_FIRST];
		r_d.igmp_ports = r_q.cfg[CFG_IGMP_EN] ? r_q.cfg[CFG_IGMP_MSB:CFG_IGMP_LSB]
			: '0;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			r_q     <= '0;
			r_q.cfg <= CFG_RESET;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	assign awready                = r_q.aw_rdy;
	assign wready                 = r_q.w_rdy;
	assign bvalid                 = r_q.bvalid;
	assign bresp                  = r_q.bresp;
	assign arready                = r_q.ar_rdy;
	assign rvalid                 = r_q.rvalid;
	assign rdata                  = r_q.rdata;
	assign rresp                  = r_q.rresp;
	assign vlan_enable            = r_q.cfg[CFG_VLAN_EN];
	assign tag_priority_over_ip   = r_q.cfg[CFG_TAG_FIRST];
	assign vlan_tag_first         = r_q.vlan_first;
	assign use_ip_priority        = r_q.cfg[CFG_USE_IP];
	assign ip_priority_from_table = r_q.ip_table;
	assign da_static_priority     = r_q.cfg[CFG_DA_PRIO];
	assign drop_unknown_unicast   = r_q.cfg[CFG_DROP_UC];
	assign drop_unknown_multicast = r_q.cfg[CFG_FILT_MC];
	assign counter_read_test_mode = r_q.cfg[CFG_CTR_TEST];
	assign counter_reload_value   = r_q.ctr_reload;
	assign igmp_forward_ports     = r_q.igmp_ports;
	assign monitor_echo_enable    = r_q.cfg[CFG_ECHO];

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	pend_on_launch_a: assert property (cmd_launch |=> r_q.pend && r_q.state == ST_ISSUE)
		else $error("pending flag not raised by command");
	pend_self_clear_a: assert property ($rose(r_q.pend) |-> ##1 r_q.pend ##1 !r_q.pend)
		else $error("pending flag did not clear after two cycles");
	busy_cmd_ignore_a: assert property ((wr_do && r_q.awaddr == ADDR_MAP_CMD && r_q.pend)
		|=> $stable({r_q.cmd_dir, r_q.cmd_index}))
		else $error("command changed while pending");
	mem_access_a: assert property (r_q.state == ST_ISSUE
		|-> mem_en && (mem_we == !r_q.cmd_dir) && mem_addr == r_q.cmd_index)
		else $error("table access does not match command");
	read_capture_a: assert property ((r_q.state == ST_CAPTURE && r_q.cmd_dir)
		|=> r_q.rd_prio == $past(mem_rdata))
		else $error("read data not captured");
	write_keeps_rd_a: assert property ((r_q.state == ST_CAPTURE && !r_q.cmd_dir)
		|=> $stable(r_q.rd_prio))
		else $error("table write disturbed read data");
	vlan_status_a: assert property (##1 r_q.vlan_busy == $past(vlan_cmd_busy))
		else $error("vlan status does not follow busy");
	cfg_write_a: assert property ((wr_do && r_q.awaddr == ADDR_INGR_CFG && r_q.wstrb == 4'hf)
		|=> r_q.cfg == $past(r_q.wdata[CFG_W-1:0]))
		else $error("configuration write lost");
	ip_table_sel_a: assert property (##1 r_q.ip_table
		== $past(r_q.cfg[CFG_USE_IP] && !r_q.cfg[CFG_USE_PREC]))
		else $error("ip priority source wrong");
	tag_first_a: assert property (r_q.vlan_first |-> $past(r_q.cfg[CFG_VLAN_EN]))
		else $error("tag priority without vlan enable");
	ctr_value_a: assert property ($past(r_q.cfg[CFG_CTR_TEST])
		|-> r_q.ctr_reload == CTR_TEST_VALUE)
		else $error("counter test value wrong");
	igmp_ports_a: assert property (!$past(r_q.cfg[CFG_IGMP_EN]) |-> r_q.igmp_ports == '0)
		else $error("igmp ports active while disabled");
	unmapped_resp_a: assert property ((wr_do && !wr_mapped) |=> r_q.bvalid
		&& r_q.bresp == RESP_SLVERR)
		else $error("unmapped write not refused");

	table_write_c: cover property (cmd_launch && !r_d.cmd_dir ##3 !r_q.pend);
	table_read_c: cover property (cmd_launch && r_d.cmd_dir ##3 !r_q.pend);
	busy_ignore_c: cover property (wr_do && r_q.awaddr == ADDR_MAP_CMD && r_q.pend);
	cfg_write_c: cover property (wr_do && r_q.awaddr == ADDR_INGR_CFG);

endmodule

// ---- test/host_bus_model.sv ----
// AXI4-Lite master standing in for host software, one transfer at a time.
// Assumes the bench calls its tasks from a single process.
`timescale 1ns/1ps
module host_bus_model (
	input  wire logic        mclk,
	output logic      [15:0] awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic      [31:0] wdata,
	output logic      [3:0]  wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic      [15:0] araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	// Byte strobes of the next write; the bench narrows them for partial writes
	logic [3:0] wr_strb = 4'hf;

	initial
	begin
		awaddr  = 16'h0000;
		awvalid = 1'b0;
		wdata   = 32'h0000_0000;
		wstrb   = 4'h0;
		wvalid  = 1'b0;
		bready  = 1'b0;
		araddr  = 16'h0000;
		arvalid = 1'b0;
		rready  = 1'b0;
	end

	// Address and data go out together; each drops once its own ready is seen
	task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r,
		output bit to);
		int n;
		n = 0;
		@(posedge mclk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wstrb   <= wr_strb;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid && n < 400);
		bready <= 1'b0;
		r = bresp;
		to = n >= 400;
	endtask

	task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r,
		output bit to);
		int n;
		n = 0;
		@(posedge mclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid && n < 400);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
		to = n >= 400;
	endtask
endmodule

// ---- test/tb_switch_ingress_priority_control.sv ----
// Self-checking bench: table fill and readback, lookup port, config fields, status, errors.
// Assumes host_bus_model as the only bus master.
`timescale 1ns/1ps
module tb_switch_ingress_priority_control;
	import ingress_pkg::*;
	logic        mclk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, vlan_cmd_busy;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata, counter_reload_value;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [5:0]  lookup_index;
	logic [2:0]  lookup_priority, igmp_forward_ports;
	logic        vlan_enable, tag_priority_over_ip, vlan_tag_first, use_ip_priority;
	logic        ip_priority_from_table, da_static_priority, drop_unknown_unicast;
	logic        drop_unknown_multicast, counter_read_test_mode, monitor_echo_enable;
	logic [47:0] outs;
	logic [2:0]  tbl [TABLE_DEPTH];
	logic [31:0] c;
	int          error_cnt, checked, seed, last;

	switch_ingress_priority_control dut (.mclk, .arst_n, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .vlan_cmd_busy, .lookup_index,
		.lookup_priority, .vlan_enable, .tag_priority_over_ip, .vlan_tag_first,
		.use_ip_priority, .ip_priority_from_table, .da_static_priority,
		.drop_unknown_unicast, .drop_unknown_multicast, .counter_read_test_mode,
		.counter_reload_value, .igmp_forward_ports, .monitor_echo_enable);
	host_bus_model host (.mclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready);

	assign outs = {3'h0, monitor_echo_enable, igmp_forward_ports, counter_reload_value,
		counter_read_test_mode, drop_unknown_multicast, drop_unknown_unicast,
		da_static_priority, ip_priority_from_table, use_ip_priority, vlan_tag_first,
		tag_priority_over_ip, vlan_enable};

	initial
	begin
		mclk = 1'b0;
		forever
			#25 mclk = ~mclk;
	end

	function automatic logic [47:0] exp_outs(input logic [13:0] f);
		return {3'h0, f[13], f[7] ? f[12:10] : 3'h0,
			f[6] ? CTR_TEST_VALUE : CTR_CLEAR_VALUE, f[6], f[4], f[3], f[5],
			f[9] & ~f[2], f[9], f[0] & f[1], f[1], f[0]};
	endfunction

	task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test;
		if (error_cnt == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// A spent wait bound ends the run at once
	task automatic guard(input bit to);
		if (to)
		begin
			error_cnt++;
			end_of_test();
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		bit         to;
		host.wr(a, d, r, to);
		guard(to);
		cmp(48'(r), 48'(er));
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		bit          to;
		host.rd(a, d, r, to);
		guard(to);
		cmp({14'h0, r, d}, {14'h0, er, ed});
	endtask

	task automatic wait_idle;
		logic [31:0] d;
		logic [1:0]  r;
		bit          to;
		int          n;
		n = 0;
		do
		begin
			host.rd(ADDR_MAP_PEND, d, r, to);
			guard(to);
			n++;
		end
		while (d[0] !== 1'b0 && n < 50);
		guard(n >= 50);
	endtask

	task automatic tbl_write(input int i, input logic [2:0] p);
		wr(ADDR_MAP_WDATA, {29'h0, p}, RESP_OKAY);
		wr(ADDR_MAP_CMD, 32'(i[5:0]), RESP_OKAY);
		wait_idle();
		tbl[i] = p;
	endtask

	task automatic tbl_read(input int i);
		wr(ADDR_MAP_CMD, 32'h0000_0080 | 32'(i[5:0]), RESP_OKAY);
		wait_idle();
		rd(ADDR_MAP_RDATA, {29'h0, tbl[i]}, RESP_OKAY);
		rd(ADDR_MAP_CMD, 32'h0000_0080 | 32'(i[5:0]), RESP_OKAY);
		last = i;
	endtask

	initial
	begin
		seed = 32'h0000_1942;
		error_cnt = 0;
		checked = 0;
		arst_n = 1'b0;
		vlan_cmd_busy = 1'b0;
		lookup_index = 6'h00;
		repeat (6) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		cmp(outs, exp_outs(CFG_RESET));
		rd(ADDR_INGR_CFG, 32'(CFG_RESET), RESP_OKAY);
		rd(ADDR_MAP_PEND, 32'h0000_0000, RESP_OKAY);
		rd(ADDR_VLAN_STS, 32'h0000_0000, RESP_OKAY);
		rd(16'h0004, 32'h0000_0000, RESP_SLVERR);
		wr(16'h0004, 32'hffff_ffff, RESP_SLVERR);
		// Whole table filled before any readback, since it powers up unknown
		for (int i = 0; i < TABLE_DEPTH; i++)
			tbl_write(i, 3'($random(seed)));
		for (int k = 0; k < 12; k++)
			tbl_read(k < 2 ? k * 63 : int'(6'($random(seed))));
		for (int k = 0; k < 16; k++)
		begin
			@(posedge mclk);
			lookup_index <= 6'($random(seed));
			@(posedge mclk);
			@(negedge mclk);
			cmp(48'(lookup_priority), 48'(tbl[lookup_index]));
		end
		wr(ADDR_MAP_RDATA, 32'hffff_ffff, RESP_OKAY);
		rd(ADDR_MAP_RDATA, {29'h0, tbl[last]}, RESP_OKAY);
		wr(ADDR_VLAN_STS, 32'hffff_ffff, RESP_OKAY);
		rd(ADDR_VLAN_STS, 32'h0000_0000, RESP_OKAY);
		vlan_cmd_busy <= 1'b1;
		rd(ADDR_VLAN_STS, 32'h0000_0001, RESP_OKAY);
		vlan_cmd_busy <= 1'b0;
		rd(ADDR_VLAN_STS, 32'h0000_0000, RESP_OKAY);
		for (int k = 0; k < 12; k++)
		begin
			c = k == 0 ? 32'h0000_3fff : k == 1 ? 32'h0000_0000 : $random(seed);
			wr(ADDR_INGR_CFG, c, RESP_OKAY);
			rd(ADDR_INGR_CFG, c & 32'h0000_3fff, RESP_OKAY);
			@(negedge mclk);
			cmp(outs, exp_outs(c[13:0]));
		end
		// Each byte lane of the configuration lands only under its own strobe
		wr(ADDR_INGR_CFG, 32'h0000_0000, RESP_OKAY);
		host.wr_strb = 4'h2;
		wr(ADDR_INGR_CFG, 32'hffff_ffff, RESP_OKAY);
		rd(ADDR_INGR_CFG, 32'h0000_3f00, RESP_OKAY);
		host.wr_strb = 4'h1;
		wr(ADDR_INGR_CFG, 32'hffff_ffff, RESP_OKAY);
		rd(ADDR_INGR_CFG, 32'h0000_3fff, RESP_OKAY);
		host.wr_strb = 4'hf;
		// Reset in mid-run must bring every setting back to its reset value
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		cmp(outs, exp_outs(CFG_RESET));
		rd(ADDR_INGR_CFG, 32'(CFG_RESET), RESP_OKAY);
		rd(ADDR_MAP_PEND, 32'h0000_0000, RESP_OKAY);
		rd(ADDR_MAP_RDATA, 32'h0000_0000, RESP_OKAY);
		end_of_test();
	end
endmodule
